// file: fcsu_pkg.sv
// Purpose: shared constants for the flash command and status host controller
// Assumes: 16-bit flash data bus, 22-bit word address, 10 MHz system clock
// Notes: bus timing counts are whole system cycles
package fcsu_pkg;
  // command codes written on the low data byte
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  // status bit positions
  localparam int ST_READY = 7;
  localparam int ST_ERASE_SUSP = 6;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR = 4;
  localparam int ST_VPP_LOW = 3;
  localparam int ST_PROG_SUSP = 2;
  localparam int ST_LOCK_ERR = 1;
  localparam logic [7:0] ST_RESERVED_MASK = 8'hFE;
  // widths
  localparam int DW = 16;
  localparam int AW = 22;
  // user operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_SUSPEND = 3'h3;
  localparam logic [2:0] OP_RESUME = 3'h4;
  localparam logic [2:0] OP_CLEAR = 3'h5;
  localparam logic [2:0] OP_STATUS = 3'h6;
  localparam logic [2:0] OP_IDENT = 3'h7;
  // bus strobe timing
  localparam int CLK_NS = 100;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC < 1 ? 1 : STROBE_CYC);
  // host-side states
  typedef enum logic [3:0] {
    FCSU_IDLE, FCSU_WR1, FCSU_WR2, FCSU_RD, FCSU_GAP, FCSU_POLL, FCSU_CLR, FCSU_DONE
  } fcsu_state_t;
endpackage : fcsu_pkg

// file: fcsu_strobe.sv
// Purpose: one asynchronous bus cycle (write or read) to the flash pins
// Assumes: pins are synchronous to the clock
// Notes: each cycle deasserts enables at the end so every read is a new edge
`timescale 1ns/1ps
module fcsu_strobe
  import fcsu_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // cycle request
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [DW-1:0] rdata_o,
  // flash pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [AW-1:0] a_o,
  output logic [DW-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [DW-1:0] dq_i
);
  logic [3:0] cnt_q; // strobe length counter
  logic wr_q; // latched direction
  // run one strobe; enables fall together and rise together
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 4'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      wr_q <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      a_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      rdata_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (go_i && !busy_o)
      begin
        busy_o <= 1'b1;
        cnt_q <= STROBE_CNT;
        wr_q <= wr_i;
        a_o <= addr_i;
        dq_o <= wdata_i;
        dq_oe_o <= wr_i;
        ce_n_o <= 1'b0;
        oe_n_o <= wr_i;
        we_n_o <= !wr_i;
      end
      else if (busy_o && cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      else if (busy_o)
      begin
        // data captured at the end of the low phase; status latched on the falling edge
        if (!wr_q)
          rdata_o <= dq_i;
        ce_n_o <= 1'b1;
        oe_n_o <= 1'b1;
        we_n_o <= 1'b1;
        dq_oe_o <= 1'b0;
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule : fcsu_strobe

// file: fcsu_host.sv
// What this block does
// - only resume/program/read/status/id/suspend during erase suspend
// - after erase, read then clear status
// - program is setup code then address/data
// - ready bit checked before any error bit
// - mask the reserved lowest status bit in STATUS_O; RDATA_O of a status order keeps it
// - read-array code returns to array reads
// - toggle enables for each status read
// Purpose: host controller issuing flash commands and polling status
// Assumes: device obeys its command set; user orders one operation at a time, bar a suspend while a program or erase polls
// Notes: program and erase end with a status clear, except inside an erase suspend
`timescale 1ns/1ps
module fcsu_host
  import fcsu_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // user order port
  input wire logic REQ_I,
  input wire logic [2:0] OP_I,
  input wire logic [AW-1:0] ADDR_I,
  input wire logic [DW-1:0] DATA_I,
  output logic READY_O,
  output logic DONE_O,
  output logic [DW-1:0] RDATA_O,
  output logic [7:0] STATUS_O,
  output logic SEQ_ERR_O,
  output logic ERASE_SUSP_O,
  output logic PROG_SUSP_O,
  // flash pins
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O,
  output logic [AW-1:0] FL_A_O,
  output logic [DW-1:0] FL_DQ_O,
  output logic FL_DQ_OE_O,
  input wire logic [DW-1:0] FL_DQ_I
);
  fcsu_state_t state_q, state_d; // sequencer state
  logic [2:0] op_q; // latched operation
  logic [AW-1:0] addr_q; // latched target address
  logic [DW-1:0] data_q; // latched program data
  logic esusp_q; // erase suspended as seen by host
  logic go; // start a bus cycle
  logic wr; // bus cycle direction
  logic [AW-1:0] baddr; // bus cycle address
  logic [DW-1:0] bdata; // bus cycle data
  logic sbusy, sdone; // strobe handshake
  logic [DW-1:0] operation_status; // strobe read data
  logic [7:0] status_read_value; // status with reserved bit masked
  logic engine_ready; // ready bit of last poll
  logic seq_err; // sequence error pattern
  logic op_ok; // order legal in the present suspend state
  logic [7:0] cmd1; // first write code
  logic two_wr; // operation needs a second write
  logic polls; // operation waits for ready
  logic [7:0] cmd2; // second write low byte
  logic susp_req_q; // suspend order waiting for the running poll read to end
  logic susp_take; // suspend order accepted in the middle of a job
  logic susp_go; // poll read came back busy with a suspend waiting
  logic clr_end; // order ends with a status clear
  // masked status view and decoded flags
  assign status_read_value = operation_status[7:0] & ST_RESERVED_MASK;
  assign engine_ready = status_read_value[ST_READY];
  assign seq_err = engine_ready && status_read_value[ST_PROG_ERR]
                   && status_read_value[ST_ERASE_ERR];
  // during erase suspend refuse clear and a fresh erase
  assign op_ok = !esusp_q || (op_q != OP_ERASE && op_q != OP_CLEAR);
  // first command code per operation
  assign cmd1 = (op_q == OP_READ) ? CMD_READ_ARRAY :
                (op_q == OP_PROGRAM) ? CMD_PROG_SETUP :
                (op_q == OP_ERASE) ? CMD_ERASE_SETUP :
                (op_q == OP_SUSPEND) ? CMD_SUSPEND :
                (op_q == OP_RESUME) ? CMD_RESUME :
                (op_q == OP_CLEAR) ? CMD_CLEAR_STATUS :
                (op_q == OP_STATUS) ? CMD_READ_STATUS : CMD_READ_ID;
  assign two_wr = (op_q == OP_PROGRAM) || (op_q == OP_ERASE);
  assign polls = two_wr || (op_q == OP_SUSPEND) || (op_q == OP_RESUME);
  assign cmd2 = (op_q == OP_ERASE) ? CMD_CONFIRM : data_q[7:0];
  // only a suspend order is taken while a program or erase is polled
  assign susp_take = (state_q == FCSU_POLL) && two_wr && READY_O && REQ_I
                     && (OP_I == OP_SUSPEND);
  assign susp_go = (state_q == FCSU_POLL) && sdone && !engine_ready && susp_req_q;
  // no clear while an erase stays suspended; a resumed outer job is cleared
  assign clr_end = (two_wr && !esusp_q)
                   || (op_q == OP_RESUME && (esusp_q != PROG_SUSP_O));
  // bus cycle selection per state
  assign go = (state_q == FCSU_WR1 || state_q == FCSU_WR2 || state_q == FCSU_RD
               || state_q == FCSU_POLL || state_q == FCSU_CLR) && !sbusy && !sdone;
  assign wr = (state_q != FCSU_RD) && (state_q != FCSU_POLL);
  // identifier reads use only bit zero of the address
  assign baddr = (state_q == FCSU_WR2) ? addr_q :
                 (op_q == OP_IDENT) ? {{(AW-1){1'b0}}, addr_q[0]} : addr_q;
  assign bdata = (state_q == FCSU_WR2) ? {data_q[DW-1:8], cmd2} :
                 (state_q == FCSU_CLR) ? {8'h00, CMD_CLEAR_STATUS} :
                 {8'h00, cmd1};
  fcsu_strobe u_strobe (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .go_i(go),
    .wr_i(wr),
    .addr_i(baddr),
    .wdata_i(bdata),
    .busy_o(sbusy),
    .done_o(sdone),
    .rdata_o(operation_status),
    .ce_n_o(FL_CE_N_O),
    .oe_n_o(FL_OE_N_O),
    .we_n_o(FL_WE_N_O),
    .a_o(FL_A_O),
    .dq_o(FL_DQ_O),
    .dq_oe_o(FL_DQ_OE_O),
    .dq_i(FL_DQ_I)
  );
  // next-state logic of the command sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FCSU_IDLE: if (REQ_I) state_d = FCSU_GAP;
      FCSU_GAP: state_d = op_ok ? FCSU_WR1 : FCSU_DONE;
      FCSU_WR1:
        if (sdone)
          state_d = two_wr ? FCSU_WR2 :
                    polls ? FCSU_POLL :
                    (op_q == OP_STATUS || op_q == OP_IDENT) ? FCSU_RD : FCSU_DONE;
      FCSU_WR2: if (sdone) state_d = FCSU_POLL;
      // each poll is its own enable pulse so the device relatches status
      FCSU_POLL:
        if (sdone && engine_ready)
          state_d = clr_end ? FCSU_CLR : FCSU_DONE;
        else if (susp_go)
          state_d = FCSU_WR1;
      FCSU_CLR: if (sdone) state_d = FCSU_DONE;
      FCSU_RD: if (sdone) state_d = FCSU_DONE;
      FCSU_DONE: state_d = FCSU_IDLE;
      default: state_d = FCSU_IDLE;
    endcase
  end
  // state and latched order
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_q <= FCSU_IDLE;
      susp_req_q <= 1'b0;
      op_q <= OP_READ;
      addr_q <= '0;
      data_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == FCSU_IDLE && REQ_I)
      begin
        op_q <= OP_I;
        addr_q <= ADDR_I;
        data_q <= DATA_I;
      end
      else if (susp_go)
        op_q <= OP_SUSPEND;
      // a suspend that meets the end of its job is dropped with that job
      if (state_d != FCSU_POLL)
        susp_req_q <= 1'b0;
      else if (susp_take)
        susp_req_q <= 1'b1;
    end
  end
  // user-facing results
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      READY_O <= 1'b0;
      DONE_O <= 1'b0;
      RDATA_O <= '0;
      STATUS_O <= 8'h00;
      SEQ_ERR_O <= 1'b0;
      ERASE_SUSP_O <= 1'b0;
      PROG_SUSP_O <= 1'b0;
      esusp_q <= 1'b0;
    end
    else
    begin
      READY_O <= (state_d == FCSU_IDLE)
                 || (state_d == FCSU_POLL && two_wr && !susp_req_q && !susp_take);
      DONE_O <= (state_q == FCSU_DONE);
      if (state_q == FCSU_RD && sdone)
        RDATA_O <= operation_status;
      if (state_q == FCSU_POLL && sdone)
      begin
        // error bits are judged only once ready reads high
        STATUS_O <= status_read_value;
        SEQ_ERR_O <= seq_err;
        if (engine_ready && op_q == OP_SUSPEND)
        begin
          esusp_q <= status_read_value[ST_ERASE_SUSP];
          ERASE_SUSP_O <= status_read_value[ST_ERASE_SUSP];
          PROG_SUSP_O <= status_read_value[ST_PROG_SUSP];
        end
        else if (engine_ready && op_q == OP_RESUME)
        begin
          // a resumed program leaves an outer erase suspended; otherwise the erase suspend clears
          esusp_q <= PROG_SUSP_O ? esusp_q : 1'b0;
          ERASE_SUSP_O <= PROG_SUSP_O ? esusp_q : 1'b0;
          PROG_SUSP_O <= 1'b0;
        end
      end
    end
  end
  // assertions
  AST_SUSPEND_CODE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state_q == FCSU_WR1 && go && op_q == OP_SUSPEND) |-> bdata[7:0] == 8'hB0)
    else $error("suspend code wrong");
  AST_PROG_SETUP: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state_q == FCSU_WR1 && go && op_q == OP_PROGRAM) |-> bdata[7:0] == 8'h40)
    else $error("program setup code wrong");
  AST_ERASE_CONFIRM: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state_q == FCSU_WR2 && go && op_q == OP_ERASE) |-> bdata[7:0] == 8'hD0 && baddr == addr_q)
    else $error("erase confirm wrong");
  AST_POLL_READY: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state_q == FCSU_POLL && state_d == FCSU_CLR) |-> engine_ready)
    else $error("left poll while busy");
  AST_CLEAR_AFTER: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state_q == FCSU_CLR && go) |-> bdata[7:0] == 8'h50 && !esusp_q
      && (op_q == OP_PROGRAM || op_q == OP_ERASE || op_q == OP_RESUME))
    else $error("clear misplaced");
  AST_MIDJOB_SUSP: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    susp_go |=> state_q == FCSU_WR1 && op_q == OP_SUSPEND)
    else $error("suspend order not sent");
  AST_MASK_BIT0: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    STATUS_O[0] == 1'b0)
    else $error("reserved bit leaked");
  AST_ID_ADDR: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state_q == FCSU_RD && go && op_q == OP_IDENT) |-> baddr[AW-1:1] == '0)
    else $error("identifier address not zero");
  AST_SUSP_REFUSE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (state_q == FCSU_GAP && esusp_q && op_q == OP_CLEAR) |=> state_q == FCSU_DONE)
    else $error("illegal command during suspend");
  AST_STROBE_END: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    sdone |-> FL_CE_N_O && FL_OE_N_O)
    else $error("enables not released");
  COV_ERASE: cover property (@(posedge CLK_SYS_I) state_q == FCSU_CLR && op_q == OP_ERASE);
  COV_SUSP: cover property (@(posedge CLK_SYS_I) ERASE_SUSP_O && PROG_SUSP_O);
  COV_SEQERR: cover property (@(posedge CLK_SYS_I) SEQ_ERR_O);
  COV_MIDSUSP: cover property (@(posedge CLK_SYS_I) susp_go);
  COV_IDENT: cover property (@(posedge CLK_SYS_I) state_q == FCSU_RD && op_q == OP_IDENT);
endmodule : fcsu_host

// file: fcsu_flash_model.sv
// Purpose: behavioural flash device facing the host controller pins
// Assumes: strobes move on system clock edges, so the model samples them there
// Notes: fail_i picks the outcome of the next program or erase job
`timescale 1ns/1ps
module fcsu_flash_model
  import fcsu_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h0A5C, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h0C3A, // arbitrary value
  parameter int BUSY_CYC = 12
)
(
  // pins
  input wire logic clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [AW-1:0] a_i,
  input wire logic [DW-1:0] dq_i,
  output logic [DW-1:0] dq_o,
  // test controls
  input wire logic [1:0] fail_i,
  output logic [DW-1:0] mem_o,
  output int wr_cnt_o
);
  logic [7:0] sr_q = 8'h81; // status; reserved bit driven high on purpose
  logic [1:0] mode_q = 2'h0; // 0 array, 1 status, 2 identifier
  logic [7:0] pend_q = 8'h00; // setup code awaiting its second write
  logic [7:0] err_q = 8'h00; // error bits posted when the job ends
  logic [DW-1:0] rd_q = '0; // word latched at the enable falling edge
  logic [DW-1:0] wd_q = '0; // data seen while strobed
  logic [AW-1:0] wa_q = '0; // address seen while strobed
  logic we_q = 1'b1; // last write strobe
  logic en_q = 1'b1; // last read enable
  logic ers_q = 1'b0; // job is an erase
  int busy_q = 0; // cycles left in the engine
  int susp_q = 0; // cycles saved by a suspend
  initial mem_o = '0;
  initial wr_cnt_o = 0;
  // a released bus shows the inverse of the last word, never a kind value
  // chip enable high while suspended is the low-current standby
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_q : ~rd_q;
  // command decoder and engine
  always @(posedge clk_i)
  begin
    we_q <= we_n_i | ce_n_i;
    en_q <= oe_n_i | ce_n_i;
    if (!ce_n_i && !we_n_i)
    begin
      wd_q <= dq_i;
      wa_q <= a_i;
    end
    // contents frozen at the falling enable edge
    if (en_q && !(oe_n_i | ce_n_i))
      rd_q <= (mode_q == 2'h1) ? {8'h00, sr_q} : (mode_q == 2'h0) ? mem_o :
        (a_i[AW-1:1] != '0) ? 16'hFFFF : a_i[0] ? DEV_CODE : MAKER_CODE;
    // job ends: ready plus its error bits
    if (busy_q == 1)
      sr_q <= sr_q | 8'h80 | err_q;
    if (busy_q > 0)
      busy_q <= busy_q - 1;
    if (!we_q && (we_n_i | ce_n_i))
    begin
      wr_cnt_o <= wr_cnt_o + 1;
      pend_q <= 8'h00;
      mode_q <= 2'h1;
      if (pend_q != 8'h00)
      begin
        if (wa_q[AW-1:AW-2] == 2'h3)
          sr_q <= sr_q | 8'h82; // locked block: abort, stay on status
        else
        begin
          // second write starts the job, also inside an erase suspend
          ers_q <= (pend_q == CMD_ERASE_SETUP);
          sr_q[7] <= 1'b0;
          busy_q <= BUSY_CYC;
          err_q <= (fail_i == 2'h3) ? 8'h30 : (fail_i == 2'h0) ? 8'h00 :
            ((fail_i == 2'h2) ? 8'h08 : 8'h00) | ((pend_q == CMD_ERASE_SETUP) ? 8'h20 :
            (fail_i == 2'h1) ? 8'h10 : 8'h00);
          if (pend_q != CMD_ERASE_SETUP)
            mem_o <= wd_q;
        end
      end
      else
        case (wd_q[7:0])
          CMD_READ_ARRAY: mode_q <= 2'h0;
          CMD_READ_ID: mode_q <= 2'h2;
          CMD_CLEAR_STATUS:
          begin
            sr_q <= sr_q & 8'hC5; // the only way errors go
            mode_q <= 2'h0;
          end
          CMD_PROG_SETUP, CMD_PROG_SETUP_ALT, CMD_ERASE_SETUP: pend_q <= wd_q[7:0];
          CMD_SUSPEND:
            if (busy_q > 1) // pause and report ready
            begin
              susp_q <= busy_q;
              busy_q <= 0;
              sr_q <= sr_q | (ers_q ? 8'hC0 : 8'h84);
            end
          CMD_RESUME:
            if (susp_q > 0) // restart the saved job; ready and both suspend bits clear
            begin
              busy_q <= susp_q;
              susp_q <= 0;
              sr_q <= sr_q & 8'h3B;
            end
          default: ;
        endcase
    end
  end
endmodule : fcsu_flash_model

// file: testbench.sv
// Purpose: self-checking run of the host controller against the flash model
// Assumes: one order at a time, bar a suspend given while a job polls
// Notes: every wait is bounded; a lapse counts as a mismatch
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: value mismatch", $time); end end
module testbench
  import fcsu_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h0A5C; // arbitrary value
  localparam logic [15:0] DEV = 16'h0C3A; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [2:0] op = OP_READ;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] data = '0;
  logic [1:0] fail = 2'h0;
  logic ready, done, seq_err, esusp, psusp, ce_n, oe_n, we_n, dq_oe;
  logic [DW-1:0] rdata, dq_h, dq_f, mem;
  logic [7:0] status;
  logic [AW-1:0] fl_a;
  int err_count = 0;
  int checks = 0;
  int wr_cnt, wr0;
  initial forever #50 clk = ~clk;
  fcsu_host u_fcsu_host (.CLK_SYS_I(clk), .RST_I(rst), .REQ_I(req), .OP_I(op),
    .ADDR_I(addr), .DATA_I(data), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata),
    .STATUS_O(status), .SEQ_ERR_O(seq_err), .ERASE_SUSP_O(esusp), .PROG_SUSP_O(psusp),
    .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n), .FL_A_O(fl_a),
    .FL_DQ_O(dq_h), .FL_DQ_OE_O(dq_oe), .FL_DQ_I(dq_f));
  fcsu_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV)) u_fcsu_flash_model (
    .clk_i(clk), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .a_i(fl_a), .dq_i(dq_h),
    .dq_o(dq_f), .fail_i(fail), .mem_o(mem), .wr_cnt_o(wr_cnt));
  // prints the counts and the verdict, then stops
  task automatic final_report;
  begin
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask : final_report
  // hands one order over once READY_O shows, under a bound
  task automatic issue(input logic [2:0] o, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
  begin
    n = 0;
    do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
      err_count++;
      $display("Error at %0t: ready timed out", $time);
      final_report;
    end
    op <= o;
    addr <= a;
    data <= d;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
  end
  endtask : issue
  // waits for the DONE_O pulse that ends the order, under a bound
  task automatic wait_done;
    int n;
  begin
    n = 0;
    do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
      err_count++;
      $display("Error at %0t: order timed out", $time);
      final_report;
    end
    @(posedge clk);
  end
  endtask : wait_done
  // one user order from hand-over to its end
  task automatic order(input logic [2:0] o, input logic [AW-1:0] a, input logic [DW-1:0] d);
  begin
    issue(o, a, d);
    wait_done;
  end
  endtask : order
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({ce_n, oe_n, we_n, dq_oe}, 4'hE)
    order(OP_PROGRAM, 22'h000123, 16'h5AA5);
    `CHK(status, 8'h80)
    `CHK(mem, 16'h5AA5)
    fail <= 2'h1;
    order(OP_PROGRAM, 22'h000124, 16'h0F0F);
    `CHK(status, 8'h90)
    fail <= 2'h0;
    order(OP_STATUS, '0, '0);
    `CHK(rdata[15:1], 15'h0040)
    $display("test program done");
    fail <= 2'h2;
    order(OP_ERASE, 22'h010000, '0);
    `CHK(status, 8'hA8)
    fail <= 2'h3;
    order(OP_ERASE, 22'h020000, '0);
    `CHK({seq_err, status}, 9'h1B0)
    fail <= 2'h0;
    order(OP_ERASE, 22'h030000, '0);
    `CHK({seq_err, esusp, status}, 10'h080)
    order(OP_PROGRAM, 22'h3F0000, 16'h1234);
    `CHK(status, 8'h82)
    `CHK(mem, 16'h0F0F)
    $display("test erase done");
    wr0 = wr_cnt;
    issue(OP_ERASE, 22'h040000, '0);
    issue(OP_SUSPEND, '0, '0);
    wait_done;
    `CHK({esusp, psusp, status}, 10'h2C0)
    `CHK(ce_n, 1'b1)
    order(OP_CLEAR, '0, '0);
    `CHK(wr_cnt - wr0, 3)
    order(OP_PROGRAM, 22'h000200, 16'h00FF);
    `CHK({esusp, status, mem}, 25'h1C000FF)
    order(OP_RESUME, '0, '0);
    `CHK({esusp, status}, 9'h080)
    issue(OP_PROGRAM, 22'h000300, 16'h3C3C);
    issue(OP_SUSPEND, '0, '0);
    wait_done;
    `CHK({esusp, psusp, status}, 10'h184)
    order(OP_RESUME, '0, '0);
    `CHK({psusp, status, mem}, 25'h0803C3C)
    `CHK(wr_cnt - wr0, 12)
    $display("test mid-job suspend done");
    wr0 = wr_cnt;
    order(OP_SUSPEND, '0, '0);
    order(OP_RESUME, '0, '0);
    `CHK({esusp, psusp}, 2'b00)
    `CHK(wr_cnt - wr0, 2)
    order(OP_IDENT, 22'h000000, '0);
    `CHK(rdata, MAKER)
    order(OP_IDENT, 22'h000001, '0);
    `CHK(rdata, DEV)
    order(OP_READ, 22'h000123, '0);
    `CHK(wr_cnt - wr0, 5)
    $display("test suspend and identifier done");
    final_report;
  end
endmodule : testbench
